/* File: logic/otg_role_pkg.sv */
// Constants, register map and carrier types of the dual-role sequencer.
package otg_role_pkg;

  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 125;
  localparam int TICK_CYC_DEF = CLK_MHZ * TICK_US;

  localparam int T_VRISE_US     = 100000;
  localparam int T_BCON_US      = 200000;
  localparam int T_BDIS_US      = 150000;
  localparam int T_APER_IDLE_US = 3000;
  localparam int T_SRP_IDLE_US  = 2000;
  localparam int T_SRP_PULSE_US = 5000;
  localparam int T_SRP_MAX_US   = 100000;
  localparam int T_ACON_US      = 3125;

  localparam int TW = 12;
  localparam logic [TW-1:0] T_VRISE_TK     = TW'(T_VRISE_US / TICK_US);
  localparam logic [TW-1:0] T_BCON_TK      = TW'(T_BCON_US / TICK_US);
  localparam logic [TW-1:0] T_BDIS_TK      = TW'(T_BDIS_US / TICK_US);
  localparam logic [TW-1:0] T_APER_IDLE_TK = TW'((T_APER_IDLE_US + TICK_US - 1) / TICK_US);
  localparam logic [TW-1:0] T_SRP_IDLE_TK  = TW'((T_SRP_IDLE_US + TICK_US - 1) / TICK_US);
  localparam logic [TW-1:0] T_SRP_PULSE_TK = TW'((T_SRP_PULSE_US + TICK_US - 1) / TICK_US);
  localparam logic [TW-1:0] T_SRP_MAX_TK   = TW'(T_SRP_MAX_US / TICK_US);
  localparam logic [TW-1:0] T_ACON_TK      = TW'(T_ACON_US / TICK_US);

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  localparam int CTRL_A_BUS_REQ = 0;
  localparam int CTRL_B_BUS_REQ = 1;
  localparam int CTRL_HNP_EN    = 2;
  localparam int CTRL_BCON_HOLD = 3;
  localparam int CTRL_REWAIT    = 4;
  localparam int CTRL_W         = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  localparam int CMD_A_DONE    = 0;
  localparam int CMD_A_SUSPEND = 1;
  localparam int CMD_B_DONE    = 2;

  localparam int ST_STATE = 0;
  localparam int ST_DRIVE = 4;
  localparam int ST_ID    = 8;
  localparam int ST_CONN  = 9;

  typedef enum logic [3:0] {
    st_a_idle       = 4'h0,
    st_a_wait_vrise = 4'h1,
    st_a_wait_bcon  = 4'h2,
    st_a_host       = 4'h3,
    st_a_suspend    = 4'h4,
    st_a_peripheral = 4'h5,
    st_a_wait_vfall = 4'h6,
    st_b_idle       = 4'h8,
    st_b_srp_init   = 4'h9,
    st_b_peripheral = 4'hA,
    st_b_wait_acon  = 4'hB,
    st_b_host       = 4'hC
  } otg_state_t;

  typedef struct packed {
    logic id;
    logic a_side_vbus_ok;
    logic a_side_session_ok;
    logic b_side_session_ok;
    logic b_side_session_over;
    logic peer_conn;
    logic bus_idle;
    logic bus_suspended;
    logic resume_seen;
    logic srp_seen;
  } otg_sense_t;

  typedef struct packed {
    logic host_mode_en;
    logic dplus_pullup_en;
    logic vbus_charge_en;
    logic vbus_drive_en;
  } otg_drive_t;

endpackage

/* File: logic/otg_dual_role.sv */
// Dual-role cable state sequencer with its AHB-Lite register slave.
// Operation
// - Cable identification change swaps A_IDLE and B_IDLE.
// - A_IDLE: bus request or peer session request turns VBUS on, enters VRISE.
// - VRISE: VBUS valid goes to BCON; 100 ms timeout or ID change to VFALL.
// - BCON: 200 ms without attach drops VBUS to VFALL; may wait forever.
// - BCON: VBUS valid with attach keeps host mode, enters A_HOST.
// - A_HOST: VBUS loss, done or disconnect drops host and VBUS, to VFALL.
// - A_HOST suspends on request; A_SUSPEND resumes host on bus request.
// - A_HOST: ID change or disconnect can return to BCON.
// - A_SUSPEND: ID, VBUS loss or 150 ms timeout drops VBUS to VFALL.
// - A_SUSPEND with HNP: disconnect within 150 ms drops host, to A_PERIPHERAL.
// - A_PERIPHERAL: ID change or VBUS loss drops VBUS to VFALL.
// - A_PERIPHERAL: bus idle 3 ms re-enables host, to BCON.
// - VFALL: ID change or no session and no peer returns to A_IDLE.
// - B_IDLE: B session valid enables D+ pull-up, enters B_PERIPHERAL.
// - B_IDLE: bus request, 2 ms idle and session over start SRP pulses of 5 ms.
// - SRP_INIT completes within 100 ms; completion or ID returns to B_IDLE.
// - B_PERIPHERAL: HNP, suspended bus and request drop pull-up, to WAIT_ACON.
// - WAIT_ACON: peer attach enables host mode, enters B_HOST.
// - WAIT_ACON or B_HOST: ID change or session loss returns to B_IDLE.
// - WAIT_ACON timeout 3.125 ms or resume, B_HOST done or disconnect: B_PERIPHERAL.
//
// Our own choices: the AHB-Lite register port and the address map.
module otg_dual_role #(
  parameter int TICK_CYCLES = otg_role_pkg::TICK_CYC_DEF
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire otg_role_pkg::otg_sense_t sense,
  output otg_role_pkg::otg_drive_t     drive,
  output otg_role_pkg::otg_state_t     state
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1)
  begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  otg_role_pkg::otg_state_t     next_state;
  otg_role_pkg::otg_drive_t     next_drive;
  logic [otg_role_pkg::CTRL_W-1:0] ctrl;
  logic [2:0]                   cmd;
  logic                         ph_wr;
  logic [7:0]                   ph_addr;
  logic [31:0]                  rd_word;
  logic [PW-1:0]                pre;
  logic                         tick;
  logic [otg_role_pkg::TW-1:0]  elapsed;
  logic [otg_role_pkg::TW-1:0]  idle_time;
  logic                         conn_q;
  logic                         attach;
  logic                         detach;
  logic                         a_cable;
  logic                         b_cable;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign a_cable   = ~sense.id;
  assign b_cable   = sense.id;
  assign attach    = sense.peer_conn & ~conn_q;
  assign detach    = ~sense.peer_conn & conn_q;
  assign tick      = (pre == PW'(TICK_CYCLES - 1));

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      otg_role_pkg::CTRL_OFS: rd_word[otg_role_pkg::CTRL_W-1:0] = ctrl;
      otg_role_pkg::STATUS_OFS:
      begin
        rd_word[otg_role_pkg::ST_STATE +: 4] = state;
        rd_word[otg_role_pkg::ST_DRIVE +: 4] = drive;
        rd_word[otg_role_pkg::ST_ID]         = sense.id;
        rd_word[otg_role_pkg::ST_CONN]       = sense.peer_conn;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      ph_wr   <= hsel & hready & htrans[1] & hwrite;
      ph_addr <= haddr[7:0];
      if (hsel & hready & htrans[1] & ~hwrite)
        hrdata <= rd_word;
    end
  end

  // Command bits live one cycle only, so a held request cannot re-fire a transition.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= otg_role_pkg::CTRL_RST;
      cmd  <= 3'h0;
    end
    else
    begin
      cmd <= 3'h0;
      if (ph_wr && ph_addr == otg_role_pkg::CTRL_OFS)
        ctrl <= hwdata[otg_role_pkg::CTRL_W-1:0];
      if (ph_wr && ph_addr == otg_role_pkg::CMD_OFS)
        cmd <= hwdata[2:0];
    end
  end

  // The prescaler restarts with the state, so a timeout is never short by a partial tick.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre     <= '0;
      elapsed <= '0;
    end
    else if (next_state != state)
    begin
      pre     <= '0;
      elapsed <= '0;
    end
    else
    begin
      pre <= tick ? '0 : pre + PW'(1);
      if (tick && elapsed != '1)
        elapsed <= elapsed + otg_role_pkg::TW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idle_time <= '0;
      conn_q    <= 1'b0;
    end
    else
    begin
      conn_q <= sense.peer_conn;
      if (!sense.bus_idle)
        idle_time <= '0;
      else if (tick && idle_time != '1)
        idle_time <= idle_time + otg_role_pkg::TW'(1);
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      otg_role_pkg::st_a_idle:
      begin
        if (b_cable)
          next_state = otg_role_pkg::st_b_idle;
        else if (ctrl[otg_role_pkg::CTRL_A_BUS_REQ] || sense.srp_seen)
          next_state = otg_role_pkg::st_a_wait_vrise;
      end
      otg_role_pkg::st_a_wait_vrise:
      begin
        if (b_cable)
          next_state = otg_role_pkg::st_a_wait_vfall;
        else if (sense.a_side_vbus_ok)
          next_state = otg_role_pkg::st_a_wait_bcon;
        else if (elapsed >= otg_role_pkg::T_VRISE_TK)
          next_state = otg_role_pkg::st_a_wait_vfall;
      end
      otg_role_pkg::st_a_wait_bcon:
      begin
        if (b_cable)
          next_state = otg_role_pkg::st_a_wait_vfall;
        else if (sense.a_side_vbus_ok && attach)
          next_state = otg_role_pkg::st_a_host;
        else if (!ctrl[otg_role_pkg::CTRL_BCON_HOLD] && elapsed >= otg_role_pkg::T_BCON_TK)
          next_state = otg_role_pkg::st_a_wait_vfall;
      end
      otg_role_pkg::st_a_host:
      begin
        if (b_cable)
          next_state = otg_role_pkg::st_a_wait_bcon;
        else if (!sense.a_side_vbus_ok || cmd[otg_role_pkg::CMD_A_DONE])
          next_state = otg_role_pkg::st_a_wait_vfall;
        else if (detach)
          next_state = ctrl[otg_role_pkg::CTRL_REWAIT] ? otg_role_pkg::st_a_wait_bcon
                                                        : otg_role_pkg::st_a_wait_vfall;
        else if (cmd[otg_role_pkg::CMD_A_SUSPEND])
          next_state = otg_role_pkg::st_a_suspend;
      end
      otg_role_pkg::st_a_suspend:
      begin
        if (b_cable || !sense.a_side_vbus_ok || elapsed >= otg_role_pkg::T_BDIS_TK)
          next_state = otg_role_pkg::st_a_wait_vfall;
        else if (detach)
          next_state = ctrl[otg_role_pkg::CTRL_HNP_EN] ? otg_role_pkg::st_a_peripheral
                                                        : otg_role_pkg::st_a_wait_vfall;
        else if (ctrl[otg_role_pkg::CTRL_A_BUS_REQ])
          next_state = otg_role_pkg::st_a_host;
      end
      otg_role_pkg::st_a_peripheral:
      begin
        if (b_cable || !sense.a_side_vbus_ok)
          next_state = otg_role_pkg::st_a_wait_vfall;
        else if (idle_time >= otg_role_pkg::T_APER_IDLE_TK)
          next_state = otg_role_pkg::st_a_wait_bcon;
      end
      otg_role_pkg::st_a_wait_vfall:
      begin
        if (b_cable || (!sense.a_side_session_ok && !sense.peer_conn))
          next_state = otg_role_pkg::st_a_idle;
      end
      otg_role_pkg::st_b_idle:
      begin
        if (a_cable)
          next_state = otg_role_pkg::st_a_idle;
        else if (sense.b_side_session_ok)
          next_state = otg_role_pkg::st_b_peripheral;
        else if (ctrl[otg_role_pkg::CTRL_B_BUS_REQ] && sense.b_side_session_over &&
                 idle_time >= otg_role_pkg::T_SRP_IDLE_TK)
          next_state = otg_role_pkg::st_b_srp_init;
      end
      otg_role_pkg::st_b_srp_init:
      begin
        if (a_cable || elapsed >= otg_role_pkg::T_SRP_MAX_TK ||
            (elapsed >= otg_role_pkg::T_SRP_PULSE_TK && sense.b_side_session_ok))
          next_state = otg_role_pkg::st_b_idle;
      end
      otg_role_pkg::st_b_peripheral:
      begin
        if (a_cable || !sense.b_side_session_ok)
          next_state = otg_role_pkg::st_b_idle;
        else if (ctrl[otg_role_pkg::CTRL_HNP_EN] && sense.bus_suspended &&
                 ctrl[otg_role_pkg::CTRL_B_BUS_REQ])
          next_state = otg_role_pkg::st_b_wait_acon;
      end
      otg_role_pkg::st_b_wait_acon:
      begin
        if (a_cable || !sense.b_side_session_ok)
          next_state = otg_role_pkg::st_b_idle;
        else if (attach)
          next_state = otg_role_pkg::st_b_host;
        else if (elapsed >= otg_role_pkg::T_ACON_TK || sense.resume_seen)
          next_state = otg_role_pkg::st_b_peripheral;
      end
      otg_role_pkg::st_b_host:
      begin
        if (a_cable || !sense.b_side_session_ok)
          next_state = otg_role_pkg::st_b_idle;
        else if (cmd[otg_role_pkg::CMD_B_DONE] || detach)
          next_state = otg_role_pkg::st_b_peripheral;
      end
      default:
      begin
        next_state = otg_role_pkg::st_b_idle;
      end
    endcase
  end

  // Drives follow the state being entered; SRP pulses end after the pulse window.
  always_comb
  begin
    next_drive = '0;
    case (next_state)
      otg_role_pkg::st_a_wait_vrise, otg_role_pkg::st_a_peripheral:
      begin
        next_drive.vbus_drive_en   = 1'b1;
        next_drive.dplus_pullup_en = (next_state == otg_role_pkg::st_a_peripheral);
      end
      otg_role_pkg::st_a_wait_bcon, otg_role_pkg::st_a_host, otg_role_pkg::st_a_suspend:
      begin
        next_drive.vbus_drive_en = 1'b1;
        next_drive.host_mode_en  = 1'b1;
      end
      otg_role_pkg::st_b_srp_init:
      begin
        next_drive.vbus_charge_en  = (state != next_state) ||
                                     (elapsed < otg_role_pkg::T_SRP_PULSE_TK);
        next_drive.dplus_pullup_en = next_drive.vbus_charge_en;
      end
      otg_role_pkg::st_b_peripheral: next_drive.dplus_pullup_en = 1'b1;
      otg_role_pkg::st_b_host: next_drive.host_mode_en = 1'b1;
      default: next_drive = '0;
    endcase
  end

  // Reset lands in B_IDLE with every drive off, so no VBUS is sourced before ID is seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= otg_role_pkg::st_b_idle;
      drive <= '0;
    end
    else
    begin
      state <= next_state;
      drive <= next_drive;
    end
  end

  property p_id_swap;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_idle && sense.id) |=> (state == otg_role_pkg::st_b_idle);
  endproperty
  a_id_swap: assert property (p_id_swap) else $error("ID change did not reach B_IDLE");

  property p_vrise_on;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_idle && !sense.id && sense.srp_seen)
      |=> (state == otg_role_pkg::st_a_wait_vrise && drive.vbus_drive_en);
  endproperty
  a_vrise_on: assert property (p_vrise_on) else $error("SRP did not power VBUS");

  property p_vrise_timeout;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_wait_vrise && !sense.a_side_vbus_ok &&
     elapsed >= otg_role_pkg::T_VRISE_TK)
      |=> (state == otg_role_pkg::st_a_wait_vfall && !drive.vbus_drive_en);
  endproperty
  a_vrise_timeout: assert property (p_vrise_timeout) else $error("VRISE timeout missed");

  property p_bcon_timeout;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_wait_bcon && !sense.id && !attach &&
     !ctrl[otg_role_pkg::CTRL_BCON_HOLD] && elapsed >= otg_role_pkg::T_BCON_TK)
      |=> (state == otg_role_pkg::st_a_wait_vfall && !drive.vbus_drive_en);
  endproperty
  a_bcon_timeout: assert property (p_bcon_timeout) else $error("BCON timeout missed");

  property p_host_entry;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_wait_bcon && !sense.id && sense.a_side_vbus_ok && attach)
      |=> (state == otg_role_pkg::st_a_host && drive.host_mode_en && drive.vbus_drive_en);
  endproperty
  a_host_entry: assert property (p_host_entry) else $error("attach did not enter A_HOST");

  property p_host_drop;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_host && !sense.id && !sense.a_side_vbus_ok)
      |=> (state == otg_role_pkg::st_a_wait_vfall && !drive.host_mode_en && !drive.vbus_drive_en);
  endproperty
  a_host_drop: assert property (p_host_drop) else $error("VBUS loss kept host mode");

  property p_hnp_handover;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_a_suspend && !sense.id && sense.a_side_vbus_ok && detach &&
     ctrl[otg_role_pkg::CTRL_HNP_EN] && elapsed < otg_role_pkg::T_BDIS_TK)
      |=> (state == otg_role_pkg::st_a_peripheral && !drive.host_mode_en);
  endproperty
  a_hnp_handover: assert property (p_hnp_handover) else $error("HNP handover missed");
  property p_b_session;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_b_idle && sense.id && sense.b_side_session_ok)
      |=> (state == otg_role_pkg::st_b_peripheral && drive.dplus_pullup_en);
  endproperty
  a_b_session: assert property (p_b_session) else $error("session did not raise pull-up");
  property p_srp_bound;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_b_srp_init) |-> (elapsed <= otg_role_pkg::T_SRP_MAX_TK);
  endproperty
  a_srp_bound: assert property (p_srp_bound) else $error("SRP overran its limit");

  property p_acon_timeout;
    @(posedge hclk) disable iff (!hresetn)
    (state == otg_role_pkg::st_b_wait_acon && sense.id && sense.b_side_session_ok && !attach &&
     elapsed >= otg_role_pkg::T_ACON_TK) |=> (state == otg_role_pkg::st_b_peripheral);
  endproperty
  a_acon_timeout: assert property (p_acon_timeout) else $error("WAIT_ACON timeout missed");

  property p_timer_restart;
    @(posedge hclk) disable iff (!hresetn)
    (state != $past(state)) |-> (elapsed == '0 && pre == '0);
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer kept old count");

endmodule

/* File: sim/otg_peer.sv */
// Behavioural model of the cable peer and of the VBUS rail seen by the sequencer.
module otg_peer (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire otg_role_pkg::otg_drive_t drive,
  input  wire otg_role_pkg::otg_sense_t ctl,
  input  wire logic [7:0]               rise_dly,
  output otg_role_pkg::otg_sense_t      sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl;
  // The rail climbs and decays over several cycles, so session valid outlasts the drive while VBUS valid drops at once.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl <= 8'h00;
    else if (drive.vbus_drive_en && lvl < rise_dly)
      lvl <= lvl + 8'h01;
    else if (!drive.vbus_drive_en && lvl != 8'h00)
      lvl <= lvl - 8'h01;
  end
  // An all-ones delay stands for a supply too weak ever to become valid.
  always_comb
  begin
    sense = ctl;
    sense.a_side_vbus_ok = drive.vbus_drive_en && lvl == rise_dly && rise_dly != 8'hFF;
    sense.a_side_session_ok = lvl != 8'h00;
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking testbench of the dual-role sequencer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic                     hclk = 1'b0;
  logic                     hresetn = 1'b0;
  logic                     hsel = 1'b0;
  logic [31:0]              haddr = 32'h0;
  logic [1:0]               htrans = 2'h0;
  logic                     hwrite = 1'b0;
  logic [31:0]              hwdata = 32'h0;
  logic                     hreadyout;
  logic                     hresp;
  logic [31:0]              hrdata;
  logic [31:0]              rd;
  logic [31:0]              d;
  logic [7:0]               rise_dly = 8'h05;
  otg_role_pkg::otg_sense_t ctl = 10'h200;
  otg_role_pkg::otg_sense_t sense;
  otg_role_pkg::otg_drive_t drive;
  otg_role_pkg::otg_state_t state;
  int                       mismatches = 0;
  int                       samples_checked = 0;
  int                       n;

  // The clock is never slowed or stopped while the sequencer sits on the bus.
  always #2 hclk = ~hclk;

  otg_dual_role #(.TICK_CYCLES(TK)) otg_dual_role_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense),
    .drive(drive), .state(state));
  otg_peer otg_peer_inst (.hclk(hclk), .hresetn(hresetn), .drive(drive), .ctl(ctl),
    .rise_dly(rise_dly), .sense(sense));

  function automatic int cyc(input int ticks);
    return ticks * TK;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A timeout is accepted up to one tick late, with two cycles of slack at either end.
  task automatic chk_time(input int ticks);
    check((n >= cyc(ticks) - 2 && n <= cyc(ticks + 1) + 2) ? cyc(ticks) : n, cyc(ticks));
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_st(input otg_role_pkg::otg_state_t s, input int max);
    n = 0;
    @(negedge hclk);
    while (state !== s && n < max)
    begin
      @(negedge hclk);
      n++;
    end
    check(state, s);
  endtask

  initial
  begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    conclude();
  end

  initial
  begin
    n = $urandom(32'hCAC6);
    repeat (10) @(negedge hclk);
    check(state, otg_role_pkg::st_b_idle);
    check(drive, 4'h0);
    @(posedge hclk) hresetn <= 1'b1;
    repeat (8)
    begin
      d = $urandom();
      bus(1'b1, otg_role_pkg::CTRL_OFS, d);
      bus(1'b0, otg_role_pkg::CTRL_OFS, 32'h0);
      check(rd, d & 32'h1F);
    end
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h0);
    bus(1'b1, otg_role_pkg::STATUS_OFS, 32'hFFFFFFFF);
    bus(1'b0, otg_role_pkg::STATUS_OFS, 32'h0);
    check(rd, 32'h108);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, otg_role_pkg::CMD_OFS, 32'h0);
    check(rd, 32'h0);
    @(posedge hclk) ctl.id <= 1'b0;
    wait_st(otg_role_pkg::st_a_idle, 4);
    @(posedge hclk) ctl.id <= 1'b1;
    wait_st(otg_role_pkg::st_b_idle, 4);
    @(posedge hclk) ctl.id <= 1'b0;
    wait_st(otg_role_pkg::st_a_idle, 4);
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h1);
    wait_st(otg_role_pkg::st_a_wait_vrise, 8);
    check(drive, 4'h1);
    wait_st(otg_role_pkg::st_a_wait_bcon, 300);
    // Bus request is off here, so A_SUSPEND is not left for A_HOST at once.
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h4);
    @(posedge hclk) ctl.peer_conn <= 1'b1;
    wait_st(otg_role_pkg::st_a_host, 4);
    check(drive, 4'h9);
    bus(1'b1, otg_role_pkg::CMD_OFS, 32'h2);
    wait_st(otg_role_pkg::st_a_suspend, 4);
    @(posedge hclk) ctl.peer_conn <= 1'b0;
    wait_st(otg_role_pkg::st_a_peripheral, 4);
    check(drive, 4'h5);
    @(posedge hclk) ctl.bus_idle <= 1'b1;
    wait_st(otg_role_pkg::st_a_wait_bcon, 200);
    chk_time(24);
    check(drive, 4'h9);
    @(posedge hclk) ctl.bus_idle <= 1'b0;
    wait_st(otg_role_pkg::st_a_wait_vfall, 8000);
    chk_time(1600);
    check(drive, 4'h0);
    @(posedge hclk) rise_dly <= 8'hFF;
    ctl.srp_seen <= 1'b1;
    wait_st(otg_role_pkg::st_a_idle, 300);
    wait_st(otg_role_pkg::st_a_wait_vrise, 4);
    wait_st(otg_role_pkg::st_a_wait_vfall, 4000);
    chk_time(800);
    check(drive, 4'h0);
    @(posedge hclk) ctl.srp_seen <= 1'b0;
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h0);
    wait_st(otg_role_pkg::st_a_idle, 600);
    @(posedge hclk) rise_dly <= 8'(1 + $urandom_range(8));
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h11);
    wait_st(otg_role_pkg::st_a_wait_bcon, 300);
    @(posedge hclk) ctl.peer_conn <= 1'b1;
    wait_st(otg_role_pkg::st_a_host, 4);
    @(posedge hclk) ctl.peer_conn <= 1'b0;
    wait_st(otg_role_pkg::st_a_wait_bcon, 4);
    @(posedge hclk) ctl.peer_conn <= 1'b1;
    wait_st(otg_role_pkg::st_a_host, 4);
    bus(1'b1, otg_role_pkg::CMD_OFS, 32'h1);
    wait_st(otg_role_pkg::st_a_wait_vfall, 4);
    check(drive, 4'h0);
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h0);
    @(posedge hclk) ctl.peer_conn <= 1'b0;
    wait_st(otg_role_pkg::st_a_idle, 300);
    @(posedge hclk) ctl.id <= 1'b1;
    wait_st(otg_role_pkg::st_b_idle, 4);
    @(posedge hclk) ctl.b_side_session_ok <= 1'b1;
    wait_st(otg_role_pkg::st_b_peripheral, 4);
    check(drive, 4'h4);
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h6);
    @(posedge hclk) ctl.bus_suspended <= 1'b1;
    wait_st(otg_role_pkg::st_b_wait_acon, 4);
    check(drive, 4'h0);
    wait_st(otg_role_pkg::st_b_peripheral, 300);
    chk_time(25);
    wait_st(otg_role_pkg::st_b_wait_acon, 4);
    @(posedge hclk) ctl.peer_conn <= 1'b1;
    wait_st(otg_role_pkg::st_b_host, 4);
    check(drive, 4'h8);
    @(posedge hclk) ctl.bus_suspended <= 1'b0;
    ctl.peer_conn <= 1'b0;
    wait_st(otg_role_pkg::st_b_peripheral, 4);
    @(posedge hclk) ctl.bus_suspended <= 1'b1;
    wait_st(otg_role_pkg::st_b_wait_acon, 4);
    @(posedge hclk) ctl.b_side_session_ok <= 1'b0;
    wait_st(otg_role_pkg::st_b_idle, 4);
    @(posedge hclk) ctl.bus_idle <= 1'b1;
    ctl.b_side_session_over <= 1'b1;
    wait_st(otg_role_pkg::st_b_srp_init, 200);
    chk_time(16);
    check(drive, 4'h6);
    repeat (cyc(41) + 2) @(negedge hclk);
    check(drive, 4'h0);
    wait_st(otg_role_pkg::st_b_idle, 4000);
    n += cyc(41) + 2;
    chk_time(800);
    bus(1'b1, otg_role_pkg::CTRL_OFS, 32'h0);
    conclude();
  end
endmodule
